// ==== include/drs_pkg.sv ====
/*
  Channel constants, register map and types.
  Assumes a 50 MHz clock and a 32-bit register port.
*/
package drs_pkg;

  ////////////////////////////////////////////////////////////////////
  // Register port
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 32;
  localparam logic [7:0]  OFS_CTRL     = 8'h00;
  localparam logic [7:0]  OFS_REF_EN   = 8'h04;
  localparam logic [7:0]  OFS_SLAVE    = 8'h08;
  localparam logic [7:0]  OFS_HO_INT   = 8'h0C;
  localparam logic [7:0]  OFS_PSL      = 8'h10;
  localparam logic [7:0]  OFS_FLIM     = 8'h14;
  localparam logic [7:0]  OFS_MAN_HO   = 8'h18;
  localparam logic [7:0]  OFS_PRIO     = 8'h1C;
  localparam logic [7:0]  OFS_GROUP    = 8'h20;
  localparam logic [7:0]  OFS_STATUS   = 8'h24;
  localparam logic [7:0]  OFS_HO_VAL   = 8'h28;

  ////////////////////////////////////////////////////////////////////
  // Control fields
  localparam int CTRL_MODE_LSB   = 0;
  localparam int CTRL_MODE_W     = 4;
  localparam int CTRL_OP_LSB     = 4;
  localparam int CTRL_OP_W       = 2;
  localparam int CTRL_REVERT_BIT = 6;
  localparam int CTRL_HITLESS_BIT = 7;
  localparam int CTRL_ADVHO_BIT  = 8;
  localparam int CTRL_MANHO_BIT  = 9;
  localparam int CTRL_PSL_BIT    = 10;
  localparam int CTRL_MANREF_LSB = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // Status fields
  localparam int STAT_STATE_LSB  = 0;
  localparam int STAT_SEL_LSB    = 8;
  localparam int STAT_ACTIVE_BIT = 16;
  localparam int STAT_HITLESS_BIT = 17;
  localparam int STAT_ALARM_BIT  = 18;

  ////////////////////////////////////////////////////////////////////
  // Holdover and slope
  localparam int          HO_INT_W     = 6;
  localparam int          PSL_W        = 16;
  localparam longint      CLK_FREQ_HZ  = 50_000_000;
  localparam longint      HO_STEP_S    = 1;
  localparam longint      HO_STEP_CYC  = HO_STEP_S * CLK_FREQ_HZ;

  ////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [3:0] {
    REF_AUTO      = 4'h0,
    REF_MANUAL    = 4'h1,
    REF_PIN       = 4'h2,
    REF_SLAVE     = 4'h3,
    REF_PIN_SLAVE = 4'h4
  } drs_refmode_t;

  typedef enum logic [1:0] {
    OP_AUTO     = 2'h0,
    OP_LOCKED   = 2'h1,
    OP_FREERUN  = 2'h2,
    OP_HOLDOVER = 2'h3
  } drs_opmode_t;

  typedef enum logic [4:0] {
    ST_FREERUN  = 5'b00001,
    ST_ACQUIRE  = 5'b00010,
    ST_LOCKED   = 5'b00100,
    ST_HOLDOVER = 5'b01000,
    ST_RECOVER  = 5'b10000
  } drs_state_t;

endpackage

// ==== hdl/drs_channel.sv ====
/*
  Reference selection, state and holdover of one channel.
  Assumes same-clock monitors and loop; pins asynchronous.
*/
// The strobed register port and the register addresses were decided locally.
// Overview of operation
// R1 - All references invalid: enter holdover.
// R2 - Holdover uses last offset or stored filtered offset.
// R3 - Advanced: store alternately in two slots; restore older.
// R4 - Refresh interval 0 to 63 s in 1 s steps.
// R5 - Forced holdover ignores valid references.
// R6 - Manual holdover: hold state, use written offset.
// R7 - Mode 0 auto, 1 manual, 2 pin, 3 slave, 4 pin slave.
// R8 - Channel selects alone; any input may be chosen.
// R9 - Enabled and valid inputs qualify; best priority wins.
// R10 - Grouped inputs count as equal priority.
// R11 - Manual follows register or pin index, not monitors.
// R12 - Manual: named input lost means holdover.
// R13 - Slave uses only the master input.
// R14 - Pin slave: normal until slave pin, then master input.
// R15 - Non-revertive default: switch only on loss.
// R16 - Revertive: take better valid input unless same group.
// R17 - Hitless: silent internal hold, then phase compensation.
// R18 - Hitless on locked switch and on leaving holdover.
// R19 - Slope limiter enabled and set per channel.
// R20 - Frequency offset clamped to a set maximum.
// R21 - Reset to free-run, acquire on selection, then locked.
// R22 - Holdover with qualified input: recover, then locked.
// R23 - Op mode: auto, forced locked, free-run or holdover.
// R24 - Priority ties go to the lowest numbered input.
`timescale 1ns/1ps
`default_nettype none

module drs_channel #(
  parameter int     NUM_REF  = 8,
  parameter int     PRIO_W   = 4,
  parameter int     GRP_W    = 3,
  parameter int     FREQ_W   = 24,
  parameter longint STEP_CYC = drs_pkg::HO_STEP_CYC
) (
  // Clock, reset, enable
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  input  wire logic                          clkEn,
  // Register port
  input  wire logic [drs_pkg::ADDR_W-1:0]    regAddr,
  input  wire logic [drs_pkg::DATA_W-1:0]    regWrData,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic      [drs_pkg::DATA_W-1:0]    regRdData,
  // Reference monitors
  input  wire logic [NUM_REF-1:0]            refValid,
  // Pins
  input  wire logic [$clog2(NUM_REF)-1:0]    manualSelPin,
  input  wire logic                          slavePin,
  // Loop
  input  wire logic                          lockAchieved,
  input  wire logic signed [FREQ_W-1:0]      loopFreq,
  input  wire logic signed [FREQ_W-1:0]      filteredFreq,
  input  wire logic                          phaseMeasDone,
  output logic      [$clog2(NUM_REF)-1:0]    selRef,
  output logic                               selActive,
  output logic      [4:0]                    chanState,
  output logic                               loopHold,
  output logic                               integratorLoad,
  output logic signed [FREQ_W-1:0]           integratorValue,
  output logic                               holdoverAlarm,
  output logic                               phaseMeasStart,
  output logic      [FREQ_W-1:0]             freqLimit,
  output logic                               pslEnable,
  output logic      [drs_pkg::PSL_W-1:0]     pslSlope
);

  localparam int IDX_W = $clog2(NUM_REF);
  localparam int CNT_W = $clog2(STEP_CYC + 1);

  ////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [PRIO_W-1:0] prioOf(
    input logic [NUM_REF*PRIO_W-1:0] tbl,
    input logic [IDX_W-1:0]          idx
  );
    prioOf = tbl[idx*PRIO_W +: PRIO_W];
  endfunction

  function automatic logic [GRP_W-1:0] grpOf(
    input logic [NUM_REF*GRP_W-1:0] tbl,
    input logic [IDX_W-1:0]         idx
  );
    grpOf = tbl[idx*GRP_W +: GRP_W];
  endfunction

  function automatic logic signed [FREQ_W-1:0] clampFreq(
    input logic signed [FREQ_W-1:0] f,
    input logic        [FREQ_W-1:0] lim
  );
    logic signed [FREQ_W:0] sf;
    logic signed [FREQ_W:0] sl;
    sf = f;
    sl = {1'b0, lim};
    if (sf > sl)       clampFreq = FREQ_W'(sl);
    else if (sf < -sl) clampFreq = FREQ_W'(-sl);
    else               clampFreq = f;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0]                ctrl_q;
  logic [NUM_REF-1:0]         refEn_q;
  logic [IDX_W-1:0]           slaveRef_q;
  logic [drs_pkg::HO_INT_W-1:0] hoInt_q;
  logic [drs_pkg::PSL_W-1:0]  psl_q;
  logic [FREQ_W-1:0]          fLim_q;
  logic signed [FREQ_W-1:0]   manHo_q;
  logic [NUM_REF*PRIO_W-1:0]  prio_q;
  logic [NUM_REF*GRP_W-1:0]   grp_q;
  logic [drs_pkg::DATA_W-1:0] rdData_q;
  logic signed [FREQ_W-1:0]   hoA_q;
  logic signed [FREQ_W-1:0]   hoB_q;
  logic                       olderIsA_q;
  logic signed [FREQ_W-1:0]   lastFreq_q;
  logic [CNT_W-1:0]           secCnt_q;
  logic [drs_pkg::HO_INT_W-1:0] intCnt_q;
  logic [IDX_W-1:0]           selRef_q;
  logic                       selActive_q;
  logic                       hitless_q;
  logic                       measStart_q;
  logic                       load_q;
  logic signed [FREQ_W-1:0]   intVal_q;
  logic [IDX_W-1:0]           pinSync1_q;
  logic [IDX_W-1:0]           pinSync2_q;
  logic                       slvSync1_q;
  logic                       slvSync2_q;
  drs_pkg::drs_state_t        state_q;
  drs_pkg::drs_state_t        state_d;

  drs_pkg::drs_refmode_t refMode;
  drs_pkg::drs_opmode_t  opMode;
  logic                  revertive;
  logic                  hitlessEn;
  logic                  advHo;
  logic                  manHo;
  logic [IDX_W-1:0]      manRef;

  assign refMode   = drs_pkg::drs_refmode_t'(ctrl_q[drs_pkg::CTRL_MODE_LSB +: drs_pkg::CTRL_MODE_W]);
  assign opMode    = drs_pkg::drs_opmode_t'(ctrl_q[drs_pkg::CTRL_OP_LSB +: drs_pkg::CTRL_OP_W]);
  assign revertive = ctrl_q[drs_pkg::CTRL_REVERT_BIT];
  assign hitlessEn = ctrl_q[drs_pkg::CTRL_HITLESS_BIT];
  assign advHo     = ctrl_q[drs_pkg::CTRL_ADVHO_BIT];
  assign manHo     = ctrl_q[drs_pkg::CTRL_MANHO_BIT];
  assign manRef    = ctrl_q[drs_pkg::CTRL_MANREF_LSB +: IDX_W];

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinSync1_q <= '0;
      pinSync2_q <= '0;
      slvSync1_q <= 1'b0;
      slvSync2_q <= 1'b0;
    end else if (clkEn) begin
      pinSync1_q <= manualSelPin;
      pinSync2_q <= pinSync1_q;
      slvSync1_q <= slavePin;
      slvSync2_q <= slvSync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q     <= drs_pkg::CTRL_RST; // R15
      refEn_q    <= '0;
      slaveRef_q <= '0;
      hoInt_q    <= '0;
      psl_q      <= '0;
      fLim_q     <= '1;
      manHo_q    <= '0;
      prio_q     <= '0;
      grp_q      <= '0;
    end else if (clkEn && regWr) begin
      unique case (regAddr)
        drs_pkg::OFS_CTRL:   ctrl_q     <= regWrData;
        drs_pkg::OFS_REF_EN: refEn_q    <= regWrData[NUM_REF-1:0];
        drs_pkg::OFS_SLAVE:  slaveRef_q <= regWrData[IDX_W-1:0];
        drs_pkg::OFS_HO_INT: hoInt_q    <= regWrData[drs_pkg::HO_INT_W-1:0]; // R4
        drs_pkg::OFS_PSL:    psl_q      <= regWrData[drs_pkg::PSL_W-1:0]; // R19
        drs_pkg::OFS_FLIM:   fLim_q     <= regWrData[FREQ_W-1:0]; // R20
        drs_pkg::OFS_MAN_HO: manHo_q    <= regWrData[FREQ_W-1:0]; // R6
        drs_pkg::OFS_PRIO:   prio_q     <= regWrData[NUM_REF*PRIO_W-1:0];
        drs_pkg::OFS_GROUP:  grp_q      <= regWrData[NUM_REF*GRP_W-1:0]; // R10
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register reads
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData_q <= '0;
    end else if (clkEn) begin
      rdData_q <= '0;
      if (regRd) begin
        unique case (regAddr)
          drs_pkg::OFS_CTRL:   rdData_q <= ctrl_q;
          drs_pkg::OFS_REF_EN: rdData_q[NUM_REF-1:0] <= refEn_q;
          drs_pkg::OFS_SLAVE:  rdData_q[IDX_W-1:0] <= slaveRef_q;
          drs_pkg::OFS_HO_INT: rdData_q[drs_pkg::HO_INT_W-1:0] <= hoInt_q;
          drs_pkg::OFS_PSL:    rdData_q[drs_pkg::PSL_W-1:0] <= psl_q;
          drs_pkg::OFS_FLIM:   rdData_q[FREQ_W-1:0] <= fLim_q;
          drs_pkg::OFS_MAN_HO: rdData_q[FREQ_W-1:0] <= manHo_q;
          drs_pkg::OFS_PRIO:   rdData_q[NUM_REF*PRIO_W-1:0] <= prio_q;
          drs_pkg::OFS_GROUP:  rdData_q[NUM_REF*GRP_W-1:0] <= grp_q;
          drs_pkg::OFS_STATUS: begin
            rdData_q[drs_pkg::STAT_STATE_LSB +: 5] <= state_q;
            rdData_q[drs_pkg::STAT_SEL_LSB +: IDX_W] <= selRef_q;
            rdData_q[drs_pkg::STAT_ACTIVE_BIT] <= selActive_q;
            rdData_q[drs_pkg::STAT_HITLESS_BIT] <= hitless_q;
            rdData_q[drs_pkg::STAT_ALARM_BIT] <= holdoverAlarm;
          end
          drs_pkg::OFS_HO_VAL: rdData_q[FREQ_W-1:0] <= intVal_q;
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Reference selection
  logic [NUM_REF-1:0] qual;
  logic [IDX_W-1:0]   bestIdx;
  logic               bestFound;
  logic [IDX_W-1:0]   selRef_d;
  logic               selActive_d;
  logic               curOk;
  logic [IDX_W-1:0]   fixedRef;
  logic               useFixed;

  always_comb begin
    qual      = refEn_q & refValid; // R9
    bestIdx   = '0;
    bestFound = 1'b0;
    for (int i = 0; i < NUM_REF; i++) begin
      // Strict compare keeps lowest index
      if (qual[i] && (!bestFound ||
          prioOf(prio_q, IDX_W'(i)) < prioOf(prio_q, bestIdx))) begin // R9 R24
        bestIdx   = IDX_W'(i);
        bestFound = 1'b1;
      end
    end
  end

  always_comb begin
    useFixed = 1'b1;
    fixedRef = selRef_q;
    unique case (refMode) // R7
      drs_pkg::REF_AUTO:      useFixed = 1'b0;
      drs_pkg::REF_MANUAL:    fixedRef = manRef; // R11
      drs_pkg::REF_PIN:       fixedRef = pinSync2_q; // R11
      drs_pkg::REF_SLAVE:     fixedRef = slaveRef_q; // R13
      drs_pkg::REF_PIN_SLAVE: begin
        useFixed = slvSync2_q; // R14
        fixedRef = slaveRef_q;
      end
      default: ;
    endcase
  end

  always_comb begin
    curOk       = selActive_q && qual[selRef_q];
    selRef_d    = selRef_q;
    selActive_d = selActive_q;
    if (refMode > drs_pkg::REF_PIN_SLAVE) begin
      selActive_d = 1'b0;
    end else if (useFixed) begin
      // Named input only; its loss means holdover
      selRef_d    = fixedRef; // R11 R13 R14
      selActive_d = refValid[fixedRef]; // R12
    end else if (!curOk) begin
      selRef_d    = bestFound ? bestIdx : selRef_q; // R1
      selActive_d = bestFound;
    end else if (revertive && bestFound &&
                 prioOf(prio_q, bestIdx) < prioOf(prio_q, selRef_q) &&
                 !(grpOf(grp_q, bestIdx) != '0 &&
                   grpOf(grp_q, bestIdx) == grpOf(grp_q, selRef_q))) begin // R16
      selRef_d = bestIdx;
    end // R15
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      selRef_q    <= '0;
      selActive_q <= 1'b0;
    end else if (clkEn) begin
      selRef_q    <= selRef_d; // R8
      selActive_q <= selActive_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State machine
  logic forceHold;
  assign forceHold = (opMode == drs_pkg::OP_HOLDOVER) || manHo; // R5 R6

  always_comb begin
    state_d = state_q;
    if (forceHold) begin
      state_d = drs_pkg::ST_HOLDOVER; // R5 R6
    end else if (opMode == drs_pkg::OP_LOCKED) begin
      state_d = drs_pkg::ST_LOCKED; // R23
    end else if (opMode == drs_pkg::OP_FREERUN) begin
      state_d = drs_pkg::ST_FREERUN; // R23
    end else begin
      unique case (state_q)
        drs_pkg::ST_FREERUN:
          if (selActive_d) state_d = drs_pkg::ST_ACQUIRE; // R21
        drs_pkg::ST_ACQUIRE:
          if (!selActive_d) state_d = drs_pkg::ST_FREERUN;
          else if (lockAchieved && !hitless_q) state_d = drs_pkg::ST_LOCKED; // R21
        drs_pkg::ST_LOCKED:
          if (!selActive_d) state_d = drs_pkg::ST_HOLDOVER; // R1
        drs_pkg::ST_HOLDOVER:
          if (selActive_d) state_d = drs_pkg::ST_RECOVER; // R22
        drs_pkg::ST_RECOVER:
          if (!selActive_d) state_d = drs_pkg::ST_HOLDOVER;
          else if (lockAchieved && !hitless_q) state_d = drs_pkg::ST_LOCKED; // R22
        default: state_d = drs_pkg::ST_FREERUN;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) state_q <= drs_pkg::ST_FREERUN; // R21
    else if (clkEn) state_q <= state_d;
  end

  ////////////////////////////////////////////////////////////////////
  // Hitless switching
  logic hitTrig;
  assign hitTrig = hitlessEn &&
                   ((state_q == drs_pkg::ST_LOCKED && selActive_d &&
                     selRef_d != selRef_q) ||
                    (holdoverAlarm &&
                     state_d != drs_pkg::ST_HOLDOVER)); // R18

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hitless_q   <= 1'b0;
      measStart_q <= 1'b0;
    end else if (clkEn) begin
      measStart_q <= hitTrig;
      // Trigger wins over same-cycle completion
      if (hitTrig) hitless_q <= 1'b1; // R17
      else if (phaseMeasDone) hitless_q <= 1'b0; // R17
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Holdover storage
  logic secTick;
  logic storeNow;
  assign secTick  = (secCnt_q == CNT_W'(STEP_CYC - 1));
  assign storeNow = (state_q == drs_pkg::ST_LOCKED) &&
                    (hoInt_q == '0 || (secTick && intCnt_q == hoInt_q - 1'b1)); // R4

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      secCnt_q <= '0;
      intCnt_q <= '0;
    end else if (clkEn) begin
      if (state_q != drs_pkg::ST_LOCKED) begin
        secCnt_q <= '0;
        intCnt_q <= '0;
      end else if (secTick) begin
        secCnt_q <= '0;
        intCnt_q <= storeNow ? '0 : intCnt_q + 1'b1; // R4
      end else begin
        secCnt_q <= secCnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hoA_q      <= '0;
      hoB_q      <= '0;
      olderIsA_q <= 1'b1;
    end else if (clkEn && storeNow) begin
      // Overwrite older slot; other becomes older
      if (olderIsA_q) hoA_q <= filteredFreq; // R3
      else hoB_q <= filteredFreq; // R3
      olderIsA_q <= !olderIsA_q;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) lastFreq_q <= '0;
    else if (clkEn && !holdoverAlarm && !hitless_q)
      lastFreq_q <= loopFreq; // R2
  end

  ////////////////////////////////////////////////////////////////////
  // Integrator load
  logic signed [FREQ_W-1:0] hoSrc;
  logic                     hoEntry;
  always_comb begin
    if (manHo) hoSrc = manHo_q; // R6
    else if (advHo) hoSrc = olderIsA_q ? hoA_q : hoB_q; // R2 R3
    else hoSrc = lastFreq_q; // R2
  end
  assign hoEntry = (state_d == drs_pkg::ST_HOLDOVER) && !holdoverAlarm;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      load_q   <= 1'b0;
      intVal_q <= '0;
    end else if (clkEn) begin
      load_q <= hoEntry || (manHo && holdoverAlarm);
      if (hoEntry || (manHo && holdoverAlarm))
        intVal_q <= clampFreq(hoSrc, fLim_q); // R20
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign regRdData       = rdData_q;
  assign selRef          = selRef_q;
  assign selActive       = selActive_q;
  assign chanState       = state_q;
  assign loopHold        = hitless_q || holdoverAlarm; // R17
  assign integratorLoad  = load_q;
  assign integratorValue = intVal_q;
  assign holdoverAlarm   = (state_q == drs_pkg::ST_HOLDOVER); // R17
  assign phaseMeasStart  = measStart_q;
  assign freqLimit       = fLim_q; // R20
  assign pslEnable       = ctrl_q[drs_pkg::CTRL_PSL_BIT]; // R19
  assign pslSlope        = psl_q; // R19

endmodule

`default_nettype wire

// ==== verif/drs_channel_monitor.sv ====
/*
  Port checks of one channel.
  Assumes clkEn held high.
*/
`timescale 1ns/1ps
`default_nettype none
module drs_channel_monitor (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Register port
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdData,
  // Channel
  input wire logic        lockAchieved,
  input wire logic        selActive,
  input wire logic [4:0]  chanState,
  input wire logic        loopHold,
  input wire logic        integratorLoad,
  input wire logic        holdoverAlarm,
  input wire logic        phaseMeasStart,
  input wire logic        pslEnable
);
  logic [31:0] ctrlQ;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) ctrlQ <= '0;
    else if (regWr && regAddr == drs_pkg::OFS_CTRL) ctrlQ <= regWrData;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_forced;
    ctrlQ[5:4] == 2'h3 || ctrlQ[9];
  endsequence
  sequence s_leave_hold;
    ctrlQ[7] && $past(chanState) == drs_pkg::ST_HOLDOVER && chanState == drs_pkg::ST_RECOVER;
  endsequence
  alarm_state_a: assert property (holdoverAlarm == (chanState == drs_pkg::ST_HOLDOVER))
    else $error("alarm not state");
  read_idle_a: assert property (!$past(regRd) |-> regRdData == '0)
    else $error("stale read data");
  forced_hold_a: assert property (s_forced [*3] |-> chanState == drs_pkg::ST_HOLDOVER)
    else $error("forced holdover left");
  manual_load_a: assert property (ctrlQ[9] [*3] |-> integratorLoad)
    else $error("no manual load");
  load_in_hold_a: assert property (integratorLoad |-> chanState == drs_pkg::ST_HOLDOVER)
    else $error("load outside hold");
  meas_hold_a: assert property (phaseMeasStart |-> loopHold)
    else $error("measure without hold");
  exit_hitless_a: assert property (s_leave_hold |-> ##[0:2] phaseMeasStart)
    else $error("no measure on exit");
  acquire_sel_a: assert property ($past(chanState) == drs_pkg::ST_FREERUN &&
    chanState == drs_pkg::ST_ACQUIRE |-> selActive) else $error("acquire unselected");
  lock_cause_a: assert property (ctrlQ[5:4] == 2'h0 && $past(chanState) ==
    drs_pkg::ST_ACQUIRE && chanState == drs_pkg::ST_LOCKED |-> $past(lockAchieved))
    else $error("lock unreported");
  psl_enable_a: assert property (pslEnable == ctrlQ[10])
    else $error("slope enable wrong");
endmodule
`default_nettype wire

// ==== verif/drs_loop_model.sv ====
/*
  Loop model: lock and phase results.
  Assumes the bench sets words and pace.
*/
`timescale 1ns/1ps
`default_nettype none
module drs_loop_model (
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               rst,
  // From the channel
  input wire logic               selActive,
  input wire logic               phaseMeasStart,
  // From the bench
  input wire logic               slow,
  input wire logic signed [23:0] freqSet,
  input wire logic signed [23:0] filtSet,
  // To the channel
  output logic                   lockAchieved,
  output logic                   phaseMeasDone,
  output logic signed [23:0]     loopFreq,
  output logic signed [23:0]     filteredFreq
);
  int lockCnt;
  int measCnt;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lockCnt <= 0;
      measCnt <= 0;
    end else begin
      lockCnt <= selActive ? lockCnt + 1 : 0;
      measCnt <= phaseMeasStart ? 1 : (measCnt > 0 && measCnt < 10) ? measCnt + 1 : 0;
    end
  end
  assign lockAchieved  = lockCnt > (slow ? 12 : 3);
  assign phaseMeasDone = measCnt == (slow ? 9 : 2);
  assign loopFreq      = freqSet;
  assign filteredFreq  = filtSet;
endmodule
`default_nettype wire

// ==== verif/drs_channel_tb_top.sv ====
/*
  Self-checking channel bench with a selection model.
  Assumes clkEn held high.
*/
`timescale 1ns/1ps
`default_nettype none
module drs_channel_tb_top;
  logic               core_clk, rst, regWr, regRd, slavePin, slow, lockAchieved;
  logic               phaseMeasDone, selActive, loopHold, integratorLoad, holdoverAlarm;
  logic               phaseMeasStart, pslEnable;
  logic [7:0]         regAddr, refValid, en;
  logic [31:0]        regWrData, regRdData, rdv, seed, grpw;
  logic [2:0]         manualSelPin, selRef;
  logic [4:0]         chanState;
  logic [15:0]        pslSlope;
  logic [23:0]        freqLimit;
  logic signed [23:0] loopFreq, filteredFreq, integratorValue, freqSet, filtSet;
  int                 errors, comparisons, starts, cur, b, prio[8];
  drs_channel #(.STEP_CYC(20)) i_drs_channel (.core_clk, .rst, .clkEn(1'b1), .regAddr,
    .regWrData, .regWr, .regRd, .regRdData, .refValid, .manualSelPin, .slavePin,
    .lockAchieved, .loopFreq, .filteredFreq, .phaseMeasDone, .selRef, .selActive,
    .chanState, .loopHold, .integratorLoad, .integratorValue, .holdoverAlarm,
    .phaseMeasStart, .freqLimit, .pslEnable, .pslSlope);
  drs_loop_model i_drs_loop_model (.core_clk, .rst, .selActive, .phaseMeasStart, .slow,
    .freqSet, .filtSet, .lockAchieved, .phaseMeasDone, .loopFreq, .filteredFreq);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(logic [31:0] g, logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask
  task automatic wrap_up();
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (phaseMeasStart === 1'b1) starts++;
  initial begin
    repeat (6000) @(posedge core_clk);
    errors++;
    wrap_up();
  end
  initial begin
    {rst, regWr, regRd, slavePin, slow} = 5'h10;
    {regAddr, regWrData, refValid} = '0;
    manualSelPin = 3'h6;
    freqSet = 24'sh001234;
    filtSet = 24'sh000567;
    seed = 32'h00003A4B;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    tick(1);
    chk(chanState, drs_pkg::ST_FREERUN);
    rd(drs_pkg::OFS_CTRL, 32'h0);
    rd(drs_pkg::OFS_FLIM, 32'hFF_FFFF);
    rd(8'h3C, 32'h0);
    wr(drs_pkg::OFS_SLAVE, 32'h3);
    for (int p = 0; p < 2; p++) begin
      rdv = xs() & 32'h3333_3333;
      grpw = p ? xs() & 32'h0024_9249 : 32'h0;
      en = xs();
      for (int i = 0; i < 8; i++) prio[i] = rdv[4*i +: 2];
      wr(drs_pkg::OFS_PRIO, rdv);
      wr(drs_pkg::OFS_GROUP, grpw);
      wr(drs_pkg::OFS_REF_EN, {24'h0, en});
      wr(drs_pkg::OFS_CTRL, p << 6);
      @(posedge core_clk) refValid <= 8'h0;
      tick(3);
      cur = -1;
      for (int k = 0; k < 40; k++) begin
        rdv = xs();
        @(posedge core_clk) refValid <= rdv[7:0];
        tick(3);
        b = -1;
        for (int i = 0; i < 8; i++) if (rdv[i] && en[i] && (b < 0 || prio[i] < prio[b])) b = i;
        if (cur < 0 || !(rdv[cur] && en[cur])) cur = b;
        else if (p && b >= 0 && prio[b] < prio[cur] && !(grpw[3*b] && grpw[3*cur])) cur = b;
        chk(selActive, cur >= 0);
        if (cur >= 0) chk(selRef, cur);
      end
    end
    wr(drs_pkg::OFS_PRIO, 32'h0);
    wr(drs_pkg::OFS_REF_EN, 32'hFF);
    slavePin <= 1'b1;
    @(posedge core_clk) refValid <= 8'h0;
    tick(3);
    @(posedge core_clk) refValid <= 8'hFF;
    for (int m = 0; m < 16; m++) begin
      wr(drs_pkg::OFS_CTRL, 32'h0005_0000 | m);
      tick(6);
      chk(selActive, m < 5);
      if (m < 5) chk(selRef, m == 0 ? 0 : m == 1 ? 5 : m == 2 ? 6 : 3);
    end
    wr(drs_pkg::OFS_CTRL, 32'h0005_0001);
    tick(10);
    chk(chanState, drs_pkg::ST_LOCKED);
    @(posedge core_clk) refValid <= 8'hDF;
    tick(3);
    chk(chanState, drs_pkg::ST_HOLDOVER);
    wr(drs_pkg::OFS_CTRL, 32'h0);
    tick(10);
    @(posedge core_clk) refValid <= 8'h0;
    tick(3);
    chk(holdoverAlarm, 1);
    chk(integratorValue, freqSet);
    slow <= 1'b1;
    @(posedge core_clk) refValid <= 8'hFF;
    tick(3);
    chk(chanState, drs_pkg::ST_RECOVER);
    tick(20);
    chk(chanState, drs_pkg::ST_LOCKED);
    wr(drs_pkg::OFS_HO_INT, 32'h0);
    wr(drs_pkg::OFS_CTRL, 32'h180);
    tick(5);
    @(posedge core_clk) refValid <= 8'h0;
    tick(3);
    chk(integratorValue, filtSet);
    @(posedge core_clk) refValid <= 8'hFF;
    tick(40);
    chk(chanState, drs_pkg::ST_LOCKED);
    chk(starts != 0, 1);
    for (int o = 1; o < 4; o++) begin
      wr(drs_pkg::OFS_CTRL, o << 4);
      tick(4);
      chk(chanState, o == 1 ? 1 << 2 : o == 2 ? 1 : 1 << 3);
    end
    wr(drs_pkg::OFS_FLIM, 32'h100);
    wr(drs_pkg::OFS_MAN_HO, 32'h7000);
    wr(drs_pkg::OFS_PSL, 32'hBEEF);
    wr(drs_pkg::OFS_CTRL, 32'h600);
    tick(3);
    chk(integratorValue, 32'h100);
    chk({pslEnable, pslSlope}, 17'h1BEEF);
    chk(freqLimit, 24'h100);
    wrap_up();
  end
endmodule
bind drs_channel drs_channel_monitor i_drs_channel_monitor (.core_clk, .rst, .regAddr,
  .regWrData, .regWr, .regRd, .regRdData, .lockAchieved, .selActive, .chanState,
  .loopHold, .integratorLoad, .holdoverAlarm, .phaseMeasStart, .pslEnable);
`default_nettype wire
